//--- bench/sgm_checker.sv
`timescale 1ns/10ps
// ----------------------------------------
// Register port and static output checks
// ----------------------------------------
module sgm_checker #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic        clock_i,
    input wire logic        reset_n_i,
    input wire logic [1:0]  reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic        reg_write_i,
    input wire logic        reg_read_i,
    input wire logic [15:0] reg_rdata_o,
    input wire logic        modulated_output_pin_o,
    input wire logic        modulated_output_oe_o,
    input wire logic        output_slew_limit_o,
    input wire logic        source_pin_drive_off_o,
    input wire logic        high_carrier_pin_drive_off_o,
    input wire logic        low_carrier_pin_drive_off_o
);
    logic [15:0] ctl_q;
    logic [15:0] car_q;
    logic [15:0] src_q;
    logic        src_seen_q = 1'b0;

    // Shadows of what software wrote, so outputs can be tied to their cause.
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            ctl_q <= sgm_pkg::CONTROL_RESET;
            car_q <= sgm_pkg::CARRIER_RESET;
        end else if (reg_write_i && reg_addr_i == sgm_pkg::ADDR_CONTROL) begin
            ctl_q <= reg_wdata_i & sgm_pkg::CONTROL_MASK;
        end else if (reg_write_i && reg_addr_i == sgm_pkg::ADDR_CARRIER) begin
            car_q <= reg_wdata_i & sgm_pkg::CARRIER_MASK;
        end else if (reg_write_i && reg_addr_i == sgm_pkg::ADDR_SOURCE) begin
            // The source shadow has no reset, like the register it mirrors.
            src_q      <= reg_wdata_i & sgm_pkg::SOURCE_MASK;
            src_seen_q <= 1'b1;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    // The stable guard allows one cycle of register lag on the level outputs.
    rdata_idle_a: assert property (!$past(reg_read_i) |-> reg_rdata_o == 16'h0000)
        else $error("read data not zero outside the answer cycle");
    read_control_a: assert property (reg_read_i && reg_addr_i == sgm_pkg::ADDR_CONTROL
        |=> reg_rdata_o == $past(ctl_q)) else $error("control read back wrong");
    read_carrier_a: assert property (reg_read_i && reg_addr_i == sgm_pkg::ADDR_CARRIER
        |=> reg_rdata_o == $past(car_q)) else $error("carrier read back wrong");
    read_status_a: assert property (reg_read_i && reg_addr_i == sgm_pkg::ADDR_STATUS |=>
        reg_rdata_o[15:3] == 13'h0000 && reg_rdata_o[0] == $past(modulated_output_pin_o))
        else $error("status read wrong");
    oe_level_a: assert property ($stable(ctl_q) |-> modulated_output_oe_o == !ctl_q[6])
        else $error("output enable does not follow control");
    slew_level_a: assert property ($stable(ctl_q) |-> output_slew_limit_o == ctl_q[5])
        else $error("slew limit does not follow control");
    drive_off_a: assert property ($stable(car_q) |-> high_carrier_pin_drive_off_o == car_q[15]
        && low_carrier_pin_drive_off_o == car_q[7]) else $error("carrier drive off wrong");
    source_drive_a: assert property (src_seen_q && $stable(src_q) |-> source_pin_drive_off_o == src_q[7])
        else $error("source drive off does not follow source");
    disabled_out_a: assert property ((!ctl_q[15] && $stable(ctl_q)) [*3]
        |-> modulated_output_pin_o == ctl_q[4]) else $error("disabled output not at invert level");

    cover property (reg_write_i && reg_addr_i == sgm_pkg::ADDR_STATUS);
    cover property (ctl_q[15] && modulated_output_pin_o);
    cover property (ctl_q[15] && $fell(modulated_output_pin_o));
endmodule

bind sgm_top sgm_checker #(.FIFO_DEPTH(FIFO_DEPTH)) i_chk (
    .clock_i(clock_i), .reset_n_i(reset_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
    .reg_rdata_o(reg_rdata_o), .modulated_output_pin_o(modulated_output_pin_o),
    .modulated_output_oe_o(modulated_output_oe_o), .output_slew_limit_o(output_slew_limit_o),
    .source_pin_drive_off_o(source_pin_drive_off_o),
    .high_carrier_pin_drive_off_o(high_carrier_pin_drive_off_o),
    .low_carrier_pin_drive_off_o(low_carrier_pin_drive_off_o));

//--- bench/sgm_far_side.sv
`timescale 1ns/10ps
// ----------------------------------------
// Peripheral outputs and external pins
// ----------------------------------------
module sgm_far_side (
    input  wire logic [15:0] level_i,
    output logic             ext_pin_o,
    output logic             car_pin_1_o,
    output logic             car_pin_2_o,
    output logic [2:0]       serial_o,
    output logic [3:0]       uart_o,
    output logic [5:0]       compare_o
);
    // pins and peripherals
    // Pads move off the clock grid so the synchronisers see real timing.
    assign #3 {car_pin_2_o, car_pin_1_o, ext_pin_o} = level_i[2:0];
    assign {compare_o, uart_o, serial_o} = level_i[15:3];
endmodule

//--- bench/sgm_top_tb.sv
`timescale 1ns/10ps
// ----------------------------------------
// Self-checking bench
// ----------------------------------------
module sgm_top_tb;
    typedef struct packed {logic is_out; logic [15:0] value;} sgm_note_s;
    logic clock_i, reset_n_i, reg_write_i, reg_read_i, mpin, cp1, cp2, idle;
    logic [1:0]  reg_addr_i;
    logic [15:0] reg_wdata_i, reg_rdata_o, level_q;
    logic [2:0]  ser;
    logic [3:0]  uart;
    logic [5:0]  cmp;
    logic        out_pin;
    sgm_note_s   notes[$];
    event        look;
    int          errors = 0;
    int          checks_done = 0;

    sgm_top i_dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .idle_i(idle),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_write_i(reg_write_i),
        .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .external_modulator_pin_i(mpin),
        .carrier_input_pin_1_i(cp1), .carrier_input_pin_2_i(cp2), .serial_out_i(ser),
        .uart_tx_i(uart), .compare_out_i(cmp), .modulated_output_pin_o(out_pin),
        .modulated_output_oe_o(), .output_slew_limit_o(), .source_pin_drive_off_o(),
        .high_carrier_pin_drive_off_o(), .low_carrier_pin_drive_off_o());
    sgm_far_side i_far (.level_i(level_q), .ext_pin_o(mpin), .car_pin_1_o(cp1),
        .car_pin_2_o(cp2), .serial_o(ser), .uart_o(uart), .compare_o(cmp));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        lfsr = {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction

    // Level bits: 0 modulator pin, 2:1 carrier pins, 5:3 serial, 9:6 uart, 15:10 compare.
    function automatic logic mod_bit(input logic [3:0] c, input logic [15:0] lv, input logic man);
        case (c)
            4'h0: mod_bit = man;
            4'h1: mod_bit = lv[0];
            4'h2, 4'h3: mod_bit = lv[c + 4'h1];
            4'hE: mod_bit = lv[5];
            4'hF: mod_bit = 1'b0;
            default: mod_bit = lv[c + 4'h2];
        endcase
    endfunction

    function automatic logic car_bit(input logic [3:0] c, input logic [15:0] lv);
        case (c)
            4'h1, 4'h2: car_bit = lv[c];
            4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8: car_bit = lv[c + 4'h7];
            default: car_bit = 1'b0;
        endcase
    endfunction

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [1:0] a, input logic [15:0] d);
        @(posedge clock_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge clock_i);
        reg_write_i <= 1'b0;
    endtask

    // The answer stands only in the cycle after the strobe, so it is noted there.
    task automatic reg_read(input logic [1:0] a, input logic [15:0] e);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge clock_i);
        reg_read_i <= 1'b0;
        notes.push_back('{1'b0, e});
        #1 -> look;
    endtask

    // Eight cycles cover the pin path of sync, buffer and output register.
    task automatic expect_out(input logic e);
        repeat (8) @(posedge clock_i);
        notes.push_back('{1'b1, {15'h0000, e}});
        #1 -> look;
    endtask

    task automatic set_level(input logic [15:0] v);
        @(posedge clock_i);
        level_q <= v;
    endtask

    // Start on whichever carrier m selects at compare 1, flip the data, then let compare 1 fall and rise.
    // While a switch waits for its edge, the status word must show the waiting state.
    task automatic sync_case(input logic [15:0] car, input logic m, input logic e2, input logic [1:0] st);
        set_level(16'h0400);
        reg_write(sgm_pkg::ADDR_CARRIER, car);
        reg_write(sgm_pkg::ADDR_CONTROL, {15'h4000, m});
        expect_out(1'b1);
        reg_write(sgm_pkg::ADDR_CONTROL, {15'h4000, !m});
        expect_out(e2);
        reg_read(sgm_pkg::ADDR_STATUS, {13'h0000, st, e2});
        set_level(16'h0000);
        expect_out(1'b0);
        set_level(16'h0400);
        expect_out(1'b0);
    endtask

    // Watcher: every result is compared with the oldest note.
    initial begin
        sgm_note_s n;
        forever begin
            @(look);
            n = notes.pop_front();
            if (n.is_out) begin
                check("output", {15'h0000, out_pin}, n.value);
            end else begin
                check("read data", reg_rdata_o, n.value);
            end
        end
    end

    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end

    initial begin
        repeat (20000) @(posedge clock_i);
        errors++;
        final_report();
    end

    initial begin
        logic [31:0] rnd;
        logic        man;
        logic [3:0]  c4;
        rnd = 32'h59E56A1C;
        {reset_n_i, reg_write_i, reg_read_i, reg_addr_i, reg_wdata_i, level_q, idle} = '0;
        repeat (4) @(posedge clock_i);
        reset_n_i <= 1'b1;
        reg_read(sgm_pkg::ADDR_CONTROL, 16'h0020);
        reg_read(sgm_pkg::ADDR_CARRIER, 16'h0000);
        for (int a = 0; a < 4; a++) begin
            reg_write(2'(a), 16'hFFFF);
        end
        reg_read(sgm_pkg::ADDR_CONTROL, 16'hA071);
        reg_read(sgm_pkg::ADDR_SOURCE, 16'h008F);
        reg_read(sgm_pkg::ADDR_CARRIER, 16'hEFEF);
        // Source survives a reset in mid-run while control returns to default.
        reg_write(sgm_pkg::ADDR_SOURCE, 16'h0005);
        @(posedge clock_i);
        reset_n_i <= 1'b0;
        @(posedge clock_i);
        reset_n_i <= 1'b1;
        reg_read(sgm_pkg::ADDR_SOURCE, 16'h0005);
        reg_read(sgm_pkg::ADDR_CONTROL, 16'h0020);
        reg_write(sgm_pkg::ADDR_CARRIER, 16'h4000);
        reg_write(sgm_pkg::ADDR_SOURCE, 16'h0000);
        reg_write(sgm_pkg::ADDR_CONTROL, 16'h0010);
        expect_out(1'b1);
        reg_read(sgm_pkg::ADDR_STATUS, {13'h0000, sgm_pkg::SGM_HIGH, 1'b1});
        reg_write(sgm_pkg::ADDR_CONTROL, 16'h8011);
        expect_out(1'b0);
        // Halt in idle parks the output at the invert level until idle drops.
        reg_write(sgm_pkg::ADDR_CONTROL, 16'hA011);
        idle <= 1'b1;
        expect_out(1'b1);
        @(posedge clock_i);
        idle <= 1'b0;
        expect_out(1'b0);
        // Pass 0 sweeps data sources, pass 1 carrier one, pass 2 carrier zero.
        for (int p = 0; p < 3; p++) begin
            for (int c = 0; c < 16; c++) begin
                rnd = lfsr(rnd);
                c4 = 4'(c);
                man = (p == 0) ? rnd[16] : (p == 1);
                set_level(rnd[15:0]);
                reg_write(sgm_pkg::ADDR_CARRIER, (p == 0) ? 16'h4000 : (p == 1) ? {4'h0, c4, 8'h00} : {12'h000, c4});
                reg_write(sgm_pkg::ADDR_SOURCE, (p == 0) ? {12'h000, c4} : 16'h0000);
                reg_write(sgm_pkg::ADDR_CONTROL, {15'h4000, man});
                expect_out((p == 0) ? mod_bit(c4, rnd[15:0], man) : car_bit(c4, rnd[15:0]));
            end
        end
        sync_case(16'h2300, 1'b1, 1'b1, sgm_pkg::SGM_WAIT_LOW);
        sync_case(16'h0023, 1'b0, 1'b1, sgm_pkg::SGM_WAIT_HI);
        sync_case(16'h0300, 1'b1, 1'b0, sgm_pkg::SGM_LOW);
        repeat (2) @(posedge clock_i);
        final_report();
    end
endmodule

//--- src/sgm_fifo.sv
`timescale 1ns/10ps
module sgm_fifo #(
    parameter int WIDTH = 4,
    parameter int DEPTH = 4
) (
    input  wire logic             clock_i,
    input  wire logic             reset_n_i,
    sgm_stream_if.sink            in_if,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               rd;
        logic [AW-1:0]               wr;
        logic [AW:0]                 cnt;
    } sgm_fifo_s;

    sgm_fifo_s st_q;
    sgm_fifo_s st_d;
    logic      push;
    logic      pop;

    // ------------------------------------------------------------------
    // Handshakes
    // ------------------------------------------------------------------
    // Full and empty come straight from the count, so no slot is wasted.
    assign in_if.ready = (st_q.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (st_q.cnt != '0);
    assign out_data_o  = st_q.mem[st_q.rd];
    assign push        = in_if.valid && in_if.ready;
    assign pop         = out_valid_o && out_ready_i;

    // Next state of pointers, count and storage.
    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.mem[st_q.wr] = in_if.data;
            st_d.wr = (st_q.wr == AW'(DEPTH-1)) ? '0 : st_q.wr + 1'b1;
        end
        if (pop) begin
            st_d.rd = (st_q.rd == AW'(DEPTH-1)) ? '0 : st_q.rd + 1'b1;
        end
        st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Storage clears with the pointers, so no stale sample can leak out after reset.
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule

//--- src/sgm_pkg.sv
package sgm_pkg;

    // ------------------------------------------------------------------
    // Register map (word offsets of the plain register port)
    // ------------------------------------------------------------------
    localparam logic [1:0]  ADDR_CONTROL    = 2'h0;
    localparam logic [1:0]  ADDR_SOURCE     = 2'h1;
    localparam logic [1:0]  ADDR_CARRIER    = 2'h2;
    localparam logic [1:0]  ADDR_STATUS     = 2'h3;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTL_ON_BIT       = 15;
    localparam int CTL_IDLE_BIT     = 13;
    localparam int CTL_PIN_ON_BIT   = 6;
    localparam int CTL_SLEW_BIT     = 5;
    localparam int CTL_INVERT_BIT   = 4;
    localparam int CTL_MANUAL_BIT   = 0;
    localparam int SRC_DRIVE_OFF_BIT = 7;
    localparam int CAR_HI_LSB       = 8;
    localparam int CAR_DRIVE_OFF_OFS = 7;
    localparam int CAR_INVERT_OFS   = 6;
    localparam int CAR_WAIT_OFS     = 5;

    // ------------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------------
    localparam logic [15:0] CONTROL_RESET   = 16'h0020;
    localparam logic [15:0] CONTROL_MASK    = 16'hA071;
    localparam logic [15:0] SOURCE_MASK     = 16'h008F;
    localparam logic [15:0] CARRIER_RESET   = 16'h0000;
    localparam logic [15:0] CARRIER_MASK    = 16'hEFEF;

    // ------------------------------------------------------------------
    // Source codes
    // ------------------------------------------------------------------
    localparam logic [3:0]  MOD_MANUAL      = 4'h0;
    localparam logic [3:0]  MOD_PIN         = 4'h1;
    localparam logic [3:0]  MOD_SERIAL1     = 4'h2;
    localparam logic [3:0]  MOD_SERIAL2     = 4'h3;
    localparam logic [3:0]  MOD_SERIAL3     = 4'hE;
    localparam logic [3:0]  MOD_NONE        = 4'hF;
    localparam logic [3:0]  CAR_GROUND      = 4'h0;
    localparam logic [3:0]  CAR_PIN1        = 4'h1;
    localparam logic [3:0]  CAR_PIN2        = 4'h2;
    localparam logic [3:0]  CAR_CMP_FIRST   = 4'h3;
    localparam logic [3:0]  CAR_CMP_LAST    = 4'h8;

    localparam int FIFO_DEPTH = 4;

    typedef enum logic [1:0] {
        SGM_HIGH     = 2'b00,
        SGM_WAIT_LOW = 2'b01,
        SGM_LOW      = 2'b11,
        SGM_WAIT_HI  = 2'b10
    } sgm_state_e;

endpackage

//--- src/sgm_stream_if.sv
`timescale 1ns/10ps
// Bit stream between the sampler and the FIFO.
interface sgm_stream_if #(parameter int WIDTH = 4);
    logic [WIDTH-1:0] data;
    logic             valid;
    logic             ready;
    modport source (output data, output valid, input ready);
    modport sink   (input data, input valid, output ready);
endinterface

//--- src/sgm_top.sv
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module sgm_top #(
    parameter int FIFO_DEPTH = sgm_pkg::FIFO_DEPTH
) (
    input  wire logic        clock_i,
    input  wire logic        reset_n_i,
    input  wire logic        idle_i,
    input  wire logic [1:0]  reg_addr_i,
    input  wire logic [15:0] reg_wdata_i,
    input  wire logic        reg_write_i,
    input  wire logic        reg_read_i,
    output logic [15:0]      reg_rdata_o,
    input  wire logic        external_modulator_pin_i,
    input  wire logic        carrier_input_pin_1_i,
    input  wire logic        carrier_input_pin_2_i,
    input  wire logic [2:0]  serial_out_i,
    input  wire logic [3:0]  uart_tx_i,
    input  wire logic [5:0]  compare_out_i,
    output logic             modulated_output_pin_o,
    output logic             modulated_output_oe_o,
    output logic             output_slew_limit_o,
    output logic             source_pin_drive_off_o,
    output logic             high_carrier_pin_drive_off_o,
    output logic             low_carrier_pin_drive_off_o
);
    typedef struct packed {
        logic [2:0]           pin_sync;
        logic [2:0]           pin_sync2;
        logic [15:0]          control;
        logic [15:0]          source;
        logic [15:0]          carrier;
        logic                 src_loaded;
        sgm_pkg::sgm_state_e  state;
        logic                 hi_prev;
        logic                 lo_prev;
        logic                 out;
        logic [15:0]          rdata;
    } sgm_top_s;

    sgm_top_s st_q;
    sgm_top_s st_d;

    sgm_stream_if #(.WIDTH(4)) samp_if ();
    logic [3:0] fifo_data;
    logic       fifo_valid;
    logic       running;

    // ------------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------------
    function automatic logic carrier_pick(input logic [3:0] code, input logic [2:0] pins,
                                          input logic [5:0] cmp);
        logic r;
        r = 1'b0;
        if (code == sgm_pkg::CAR_PIN1) begin
            r = pins[1];
        end else if (code == sgm_pkg::CAR_PIN2) begin
            r = pins[2];
        end else if (code >= sgm_pkg::CAR_CMP_FIRST && code <= sgm_pkg::CAR_CMP_LAST) begin
            r = cmp[3'(code - sgm_pkg::CAR_CMP_FIRST)];
        end
        return r;
    endfunction

    logic mod_raw;
    logic hi_car;
    logic lo_car;

    // Modulator source decode; the FIFO aligns all three picks in time.
    always_comb begin
        mod_raw = 1'b0;
        unique case (st_q.source[3:0])
            sgm_pkg::MOD_MANUAL:  mod_raw = st_q.control[sgm_pkg::CTL_MANUAL_BIT];
            sgm_pkg::MOD_PIN:     mod_raw = st_q.pin_sync2[0];
            sgm_pkg::MOD_SERIAL1: mod_raw = serial_out_i[0];
            sgm_pkg::MOD_SERIAL2: mod_raw = serial_out_i[1];
            sgm_pkg::MOD_SERIAL3: mod_raw = serial_out_i[2];
            sgm_pkg::MOD_NONE:    mod_raw = 1'b0;
            4'h4, 4'h5, 4'h6, 4'h7: mod_raw = uart_tx_i[st_q.source[1:0]];
            default:              mod_raw = compare_out_i[3'(st_q.source[3:0] - 4'h8)];
        endcase
        hi_car = carrier_pick(st_q.carrier[sgm_pkg::CAR_HI_LSB +: 4], st_q.pin_sync2, compare_out_i)
                 ^ st_q.carrier[sgm_pkg::CAR_HI_LSB + sgm_pkg::CAR_INVERT_OFS];
        lo_car = carrier_pick(st_q.carrier[3:0], st_q.pin_sync2, compare_out_i)
                 ^ st_q.carrier[sgm_pkg::CAR_INVERT_OFS];
    end

    // ------------------------------------------------------------------
    // Sample FIFO
    // ------------------------------------------------------------------
    // Samples {lo, hi, mod, 1} enter every running cycle; drained at once, so
    // latency is one cycle, but a stalled source simply drops nothing.
    assign running       = st_q.control[sgm_pkg::CTL_ON_BIT]
                           && !(idle_i && st_q.control[sgm_pkg::CTL_IDLE_BIT]);
    assign samp_if.data  = {lo_car, hi_car, mod_raw, 1'b1};
    assign samp_if.valid = running;

    sgm_fifo #(.WIDTH(4), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clock_i     (clock_i),
        .reset_n_i   (reset_n_i),
        .in_if       (samp_if),
        .out_data_o  (fifo_data),
        .out_valid_o (fifo_valid),
        .out_ready_i (1'b1)
    );

    // ------------------------------------------------------------------
    // Switching state machine and registers
    // ------------------------------------------------------------------
    logic s_mod;
    logic s_hi;
    logic s_lo;
    logic hi_fall;
    logic lo_fall;
    logic car_out;
    assign s_mod   = fifo_data[1];
    assign s_hi    = fifo_data[2];
    assign s_lo    = fifo_data[3];
    assign hi_fall = st_q.hi_prev && !s_hi;
    assign lo_fall = st_q.lo_prev && !s_lo;

    always_comb begin
        st_d      = st_q;
        car_out   = 1'b0;
        // Two flops on each external pin; only the second stage is read.
        st_d.pin_sync  = {carrier_input_pin_2_i, carrier_input_pin_1_i, external_modulator_pin_i};
        st_d.pin_sync2 = st_q.pin_sync;
        if (fifo_valid) begin
            st_d.hi_prev = s_hi;
            st_d.lo_prev = s_lo;
            unique case (st_q.state)
                sgm_pkg::SGM_HIGH: begin
                    if (!s_mod) begin
                        st_d.state = st_q.carrier[sgm_pkg::CAR_HI_LSB + sgm_pkg::CAR_WAIT_OFS] && !hi_fall
                                   ? sgm_pkg::SGM_WAIT_LOW : sgm_pkg::SGM_LOW;
                    end
                end
                sgm_pkg::SGM_WAIT_LOW: begin
                    if (!s_mod && hi_fall) st_d.state = sgm_pkg::SGM_LOW;
                    else if (s_mod) st_d.state = sgm_pkg::SGM_HIGH;
                end
                sgm_pkg::SGM_LOW: begin
                    if (s_mod) begin
                        st_d.state = st_q.carrier[sgm_pkg::CAR_WAIT_OFS] && !lo_fall
                                   ? sgm_pkg::SGM_WAIT_HI : sgm_pkg::SGM_HIGH;
                    end
                end
                sgm_pkg::SGM_WAIT_HI: begin
                    if (s_mod && lo_fall) st_d.state = sgm_pkg::SGM_HIGH;
                    else if (!s_mod) st_d.state = sgm_pkg::SGM_LOW;
                end
            endcase
            car_out = (st_d.state == sgm_pkg::SGM_HIGH || st_d.state == sgm_pkg::SGM_WAIT_LOW)
                      ? (s_hi & s_mod) | (s_hi & (st_d.state == sgm_pkg::SGM_WAIT_LOW))
                      : (s_lo & ~s_mod) | (s_lo & (st_d.state == sgm_pkg::SGM_WAIT_HI));
        end
        st_d.out = (running && fifo_valid ? car_out : 1'b0) ^ st_q.control[sgm_pkg::CTL_INVERT_BIT];

        // Register writes; unmapped addresses are ignored.
        if (reg_write_i) begin
            unique case (reg_addr_i)
                sgm_pkg::ADDR_CONTROL: st_d.control = reg_wdata_i & sgm_pkg::CONTROL_MASK;
                sgm_pkg::ADDR_SOURCE: begin
                    st_d.source     = reg_wdata_i & sgm_pkg::SOURCE_MASK;
                    st_d.src_loaded = 1'b1;
                end
                sgm_pkg::ADDR_CARRIER: st_d.carrier = reg_wdata_i & sgm_pkg::CARRIER_MASK;
                default: ;
            endcase
        end
        st_d.rdata = '0;
        if (reg_read_i) begin
            unique case (reg_addr_i)
                sgm_pkg::ADDR_CONTROL: st_d.rdata = st_q.control;
                sgm_pkg::ADDR_SOURCE:  st_d.rdata = st_q.source;
                sgm_pkg::ADDR_CARRIER: st_d.rdata = st_q.carrier;
                default: st_d.rdata = {13'h0000, st_q.state, st_q.out};
            endcase
        end
    end

    // The source register is left out of reset so its setting survives it.
    always_ff @(posedge clock_i) begin
        if (!reset_n_i) begin
            st_q.pin_sync   <= '0;
            st_q.pin_sync2  <= '0;
            st_q.control    <= sgm_pkg::CONTROL_RESET;
            st_q.carrier    <= sgm_pkg::CARRIER_RESET;
            st_q.src_loaded <= st_q.src_loaded;
            st_q.state      <= sgm_pkg::SGM_HIGH;
            st_q.hi_prev    <= 1'b0;
            st_q.lo_prev    <= 1'b0;
            st_q.out        <= 1'b0;
            st_q.rdata      <= '0;
            st_q.source     <= st_q.source;
        end else begin
            st_q <= st_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // drive output pin
    assign modulated_output_pin_o       = st_q.out;
    assign modulated_output_oe_o        = ~st_q.control[sgm_pkg::CTL_PIN_ON_BIT];
    assign output_slew_limit_o          = st_q.control[sgm_pkg::CTL_SLEW_BIT];
    assign source_pin_drive_off_o       = st_q.source[sgm_pkg::SRC_DRIVE_OFF_BIT];
    assign high_carrier_pin_drive_off_o = st_q.carrier[sgm_pkg::CAR_HI_LSB + sgm_pkg::CAR_DRIVE_OFF_OFS];
    assign low_carrier_pin_drive_off_o  = st_q.carrier[sgm_pkg::CAR_DRIVE_OFF_OFS];
    assign reg_rdata_o                  = st_q.rdata;
endmodule
